/* hw/nvm_seq_pkg.sv */
// Package for the flash block write sequencer: register map, bit fields,
// key values, timing counts and the structs that carry grouped signals.
// Assumes a 10 MHz core clock and an 11-bit word address for program flash.
package nvm_seq_pkg;

    // Register offsets in data memory space.
    localparam logic [8:0] OFF_INT_FLAGS_2 = 9'h00D;
    localparam logic [8:0] OFF_INT_ENABLES_2 = 9'h08D;
    localparam logic [8:0] OFF_DATA_LOW = 9'h10C;
    localparam logic [8:0] OFF_ADDR_LOW = 9'h10D;
    localparam logic [8:0] OFF_DATA_HIGH = 9'h10E;
    localparam logic [8:0] OFF_ADDR_HIGH = 9'h10F;
    localparam logic [8:0] OFF_CONTROL = 9'h18C;
    localparam logic [8:0] OFF_UNLOCK = 9'h18D;

    // Field positions in the control register.
    localparam int BIT_PROG_SPACE = 7;
    localparam int BIT_ERASE_SEL = 4;
    localparam int BIT_ERROR = 3;
    localparam int BIT_WRITE_ENABLE_BIT = 2;
    localparam int BIT_TRIGGER = 1;
    // Done flag and its enable share bit 4 of the interrupt pair.
    localparam int BIT_DONE = 4;

    // Reset values and constants.
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [13:0] LATCH_ERASED = 14'h3FFF;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [1:0] LAST_SLOT = 2'h3;

    // Protected segment tops per write_protect_select code; 2'h3 means none.
    localparam logic [10:0] WP_TOP_2 = 11'h1FF;
    localparam logic [10:0] WP_TOP_1 = 11'h3FF;
    localparam logic [10:0] WP_TOP_0 = 11'h7FF;

    // Timing: clock rate, power-up hold and long write time.
    localparam int CLK_HZ = 10000000;
    localparam int PWRT_MS = 72;
    localparam int PWRT_CYC = (CLK_HZ / 1000) * PWRT_MS;
    localparam int LONG_WRITE_US = 2000;
    localparam int LONG_WRITE_CYC = (CLK_HZ / 1000000) * LONG_WRITE_US;
    localparam int CNT_W = 20;

    // Unlock detector states.
    typedef enum logic [2:0] {
        UNL_IDLE = 3'b001,
        UNL_GOT_FIRST = 3'b010,
        UNL_ARMED = 3'b100
    } unlock_e;

    // One access from the processor core.
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [8:0] addr;
        logic [7:0] wdata;
    } bus_req_s;

    // Block program command towards the flash array.
    typedef struct packed {
        logic start;
        logic [10:0] addr;
        logic [3:0][13:0] words;
    } prog_cmd_s;

    // Grants for the external programming port.
    typedef struct packed {
        logic pm_read;
        logic pm_write;
        logic ee_access;
    } ext_grant_s;

    // Whole state of the sequencer.
    typedef struct packed {
        logic [7:0] data_low;
        logic [7:0] addr_low;
        logic [5:0] data_high;
        logic [2:0] addr_high;
        logic prog_space;
        logic erase_sel;
        logic error;
        logic write_enable_bit;
        logic wr;
        logic done_flag;
        logic done_en;
        unlock_e unlock;
        logic busy;
        logic pwrt_done;
        logic [CNT_W-1:0] cnt;
        logic [3:0][13:0] latch;
        prog_cmd_s cmd;
        ext_grant_s grant;
        logic [7:0] rdata;
    } seq_state_s;

endpackage

/* hw/flash_block_write_sequencer.sv */
// Flash block write sequencer: data-memory-mapped registers, unlock
// detector, four word latches, long write timer and external access gate.
// Assumes the core bus and configuration bits run on core_clk_i.
// How it works
// - Protected segment addresses never get programmed.
// - Blocks are four aligned words, never crossing.
// - Trigger programs only; no erase is issued.
// - Four 14-bit latches chosen by address bits.
// - Short write fills latch, trigger clears next.
// - Slot three fills latch and starts programming.
// - Core runs one, discards next instruction.
// - Core stalls for the long write time.
// - Latches return to 3FFF after long write.
// - Reset clears write enable; power-up timer blocks.
// - Trigger needs write enable and unlock sequence.
// - Data protection blocks external data, program writes.
// - Program protection blocks external program access.
// - Unlock port stores nothing, reads zero.
`timescale 1ns/1ps

module flash_block_write_sequencer #(
    parameter int PWRT_CYCLES = nvm_seq_pkg::PWRT_CYC,
    parameter int LONG_WRITE_CYCLES = nvm_seq_pkg::LONG_WRITE_CYC
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire nvm_seq_pkg::bus_req_s bus_i,
    output logic [7:0] rdata_o,
    input wire logic [1:0] write_protect_select_i,
    input wire logic cp_data_i,
    input wire logic cp_prog_i,
    output nvm_seq_pkg::prog_cmd_s prog_o,
    output logic cpu_stall_o,
    output logic nvm_irq_o,
    output nvm_seq_pkg::ext_grant_s ext_grant_o
);
    import nvm_seq_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State and decode.

    // Present and next state.
    seq_state_s st_r;
    seq_state_s st_nxt;
    // Full word address held in the address high and low registers.
    logic [10:0] word_addr;
    // High when the word address falls in a protected segment.
    logic addr_protected;
    // Write strobes for the control and unlock registers.
    logic wr_control;
    logic wr_unlock;
    // Software asks for a trigger in this write.
    logic trig_req;
    // Trigger accepted as a short or long write.
    logic trig_ok;
    logic trig_short;
    logic trig_long;
    // Long write timer reached its last cycle.
    logic write_end;

    // The block base and the latch slot both come from this word address.
    assign word_addr = {st_r.addr_high, st_r.addr_low};

    // Protected segment check against the configuration select.
    // Protected segment lookup.
    always_comb begin
        case (write_protect_select_i)
            2'h2: addr_protected = (word_addr <= WP_TOP_2);
            2'h1: addr_protected = (word_addr <= WP_TOP_1);
            2'h0: addr_protected = (word_addr <= WP_TOP_0);
            default: addr_protected = 1'b0;
        endcase
    end

    // Register strobes are decoded from the exact offset only.
    assign wr_control = bus_i.wr_en && (bus_i.addr == OFF_CONTROL);
    assign wr_unlock = bus_i.wr_en && (bus_i.addr == OFF_UNLOCK);
    // A trigger request is a control write with the trigger bit while idle.
    assign trig_req = wr_control && bus_i.wdata[BIT_TRIGGER] && !st_r.wr && !st_r.busy;
    // Guarded trigger acceptance.
    // The write enable that is stored, the armed detector and the finished
    // power-up hold must all be present; erase requests are not ours.
    assign trig_ok = trig_req && st_r.write_enable_bit && bus_i.wdata[BIT_WRITE_ENABLE_BIT]
        && (st_r.unlock == UNL_ARMED) && st_r.pwrt_done
        && bus_i.wdata[BIT_PROG_SPACE] && !bus_i.wdata[BIT_ERASE_SEL]
        && !addr_protected;
    // Short write when slot is not the last.
    assign trig_short = trig_ok && (st_r.addr_low[1:0] != LAST_SLOT);
    // Long write on the last slot.
    assign trig_long = trig_ok && (st_r.addr_low[1:0] == LAST_SLOT);
    assign write_end = st_r.busy && (st_r.cnt == CNT_W'(LONG_WRITE_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    // Builds the whole next state from the present state and the access.
    always_comb begin
        st_nxt = st_r;
        // The start pulse lasts one cycle unless a long write raises it again.
        st_nxt.cmd.start = 1'b0;
        if (!st_r.pwrt_done) begin
            if (st_r.cnt == CNT_W'(PWRT_CYCLES - 1)) begin
                st_nxt.pwrt_done = 1'b1;
                st_nxt.cnt = '0;
            end else begin
                st_nxt.cnt = st_r.cnt + CNT_W'(1);
            end
        end
        // Plain register writes.
        // A software clear of the done flag loses to a completion below.
        if (bus_i.wr_en) begin
            case (bus_i.addr)
                OFF_DATA_LOW: st_nxt.data_low = bus_i.wdata;
                OFF_ADDR_LOW: st_nxt.addr_low = bus_i.wdata;
                OFF_DATA_HIGH: st_nxt.data_high = bus_i.wdata[5:0];
                OFF_ADDR_HIGH: st_nxt.addr_high = bus_i.wdata[2:0];
                OFF_INT_ENABLES_2: st_nxt.done_en = bus_i.wdata[BIT_DONE];
                OFF_INT_FLAGS_2: st_nxt.done_flag = bus_i.wdata[BIT_DONE];
                OFF_CONTROL: begin
                    st_nxt.prog_space = bus_i.wdata[BIT_PROG_SPACE];
                    st_nxt.erase_sel = bus_i.wdata[BIT_ERASE_SEL];
                    // The error flag can only be cleared by software.
                    st_nxt.error = st_r.error & bus_i.wdata[BIT_ERROR];
                    st_nxt.write_enable_bit = bus_i.wdata[BIT_WRITE_ENABLE_BIT];
                end
                default: ;
            endcase
        end
        // Unlock detector, reset by any other write.
        // The unlock port only feeds this detector.
        if (bus_i.wr_en) begin
            st_nxt.unlock = UNL_IDLE;
            if (wr_unlock && bus_i.wdata == KEY_FIRST) begin
                st_nxt.unlock = UNL_GOT_FIRST;
            end else if (wr_unlock && bus_i.wdata == KEY_SECOND
                         && st_r.unlock == UNL_GOT_FIRST) begin
                st_nxt.unlock = UNL_ARMED;
            end
        end
        // Trigger bit lives for one cycle on a short write.
        if (st_r.wr && !st_r.busy) begin
            st_nxt.wr = 1'b0;
        end
        // Selected latch takes the data word.
        if (trig_ok) begin
            st_nxt.wr = 1'b1;
            st_nxt.latch[st_r.addr_low[1:0]] = {st_r.data_high, st_r.data_low};
        end
        // Block address is the aligned base.
        // Only a program command is issued.
        if (trig_long) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt = '0;
            st_nxt.cmd.start = 1'b1;
            st_nxt.cmd.addr = {word_addr[10:2], 2'h0};
            st_nxt.cmd.words = st_r.latch;
            st_nxt.cmd.words[LAST_SLOT] = {st_r.data_high, st_r.data_low};
        end
        if (st_r.busy) begin
            st_nxt.cnt = st_r.cnt + CNT_W'(1);
        end
        // Latches erased and done flag raised at the end.
        // Done flag set wins over a software clear.
        if (write_end) begin
            st_nxt.busy = 1'b0;
            st_nxt.wr = 1'b0;
            st_nxt.cnt = '0;
            st_nxt.done_flag = 1'b1;
            for (int i = 0; i < 4; i++) begin
                st_nxt.latch[i] = LATCH_ERASED;
            end
        end
        // Program and data protection gate external program and data access.
        st_nxt.grant.pm_read = !cp_prog_i;
        st_nxt.grant.pm_write = !cp_prog_i && !cp_data_i;
        st_nxt.grant.ee_access = !cp_data_i;
        // Read data, one cycle after the read strobe.
        st_nxt.rdata = RESET_BYTE;
        if (bus_i.rd_en) begin
            case (bus_i.addr)
                OFF_DATA_LOW: st_nxt.rdata = st_r.data_low;
                OFF_ADDR_LOW: st_nxt.rdata = st_r.addr_low;
                OFF_DATA_HIGH: st_nxt.rdata = {2'h0, st_r.data_high};
                OFF_ADDR_HIGH: st_nxt.rdata = {5'h00, st_r.addr_high};
                OFF_INT_FLAGS_2: st_nxt.rdata = {3'h0, st_r.done_flag, 4'h0};
                OFF_INT_ENABLES_2: st_nxt.rdata = {3'h0, st_r.done_en, 4'h0};
                OFF_CONTROL: st_nxt.rdata = {st_r.prog_space, 2'h0, st_r.erase_sel,
                    st_r.error, st_r.write_enable_bit, st_r.wr, 1'b0};
                default: st_nxt.rdata = RESET_BYTE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.

    // Registers the next state; reset brings every field to a constant.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            st_r <= '0;
            st_r.unlock <= UNL_IDLE;
            st_r.write_enable_bit <= 1'b0;
            // Latches come up erased, just as after a long write.
            for (int i = 0; i < 4; i++) begin
                st_r.latch[i] <= LATCH_ERASED;
            end
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Data outputs come straight from registered state.
    assign rdata_o = st_r.rdata;
    assign prog_o = st_r.cmd;
    // Core stalls while the array is written.
    // The core squashes the slot after the trigger itself.
    assign cpu_stall_o = st_r.busy;
    // Pending request when flag and enable meet.
    assign nvm_irq_o = st_r.done_flag && st_r.done_en;
    assign ext_grant_o = st_r.grant;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    // A short write: the trigger bit stands for one cycle, then drops.
    sequence s_short_pulse;
        st_r.wr ##1 !st_r.wr;
    endsequence

    // A long write opens with one start pulse while the stall stands.
    sequence s_long_begin;
        prog_o.start && cpu_stall_o ##1 !prog_o.start && cpu_stall_o;
    endsequence

    // Accepted triggers and what they load or start.
    a_short_pulse: assert property (trig_short |=> s_short_pulse)
        else $error("short write trigger did not last one cycle");
    a_short_nostall: assert property (trig_short |=> !cpu_stall_o && !prog_o.start)
        else $error("short write stalled the core or started programming");
    a_latch_load: assert property (trig_short |=>
        st_r.latch[$past(st_r.addr_low[1:0])] == $past({st_r.data_high, st_r.data_low}))
        else $error("selected latch did not take the data word");
    a_long_start: assert property (trig_long |=> s_long_begin)
        else $error("long write did not start programming");
    a_block_align: assert property (prog_o.start |-> prog_o.addr[1:0] == 2'h0)
        else $error("block address not aligned");
    // Refusals: a refused trigger leaves the trigger bit low.
    a_protect_block: assert property (trig_req && addr_protected |=>
        !st_r.wr && !prog_o.start)
        else $error("protected address accepted");
    a_erase_refuse: assert property (trig_req && bus_i.wdata[BIT_ERASE_SEL]
        |=> !st_r.wr)
        else $error("erase request accepted as a trigger");
    a_space_refuse: assert property (trig_req && !bus_i.wdata[BIT_PROG_SPACE]
        |=> !st_r.wr)
        else $error("data space trigger accepted");
    a_trigger_guard: assert property ($rose(st_r.wr) |->
        $past(st_r.unlock) == UNL_ARMED && $past(st_r.write_enable_bit))
        else $error("trigger accepted without unlock or enable");
    a_pwrt_block: assert property ($rose(st_r.wr) |-> $past(st_r.pwrt_done))
        else $error("write during power-up hold");
    a_write_enable_bit_reset: assert property ($rose(resetn_i) |-> !st_r.write_enable_bit && !st_r.pwrt_done)
        else $error("write enable or hold not cleared by reset");
    // Completion of a long write.
    a_latch_erase: assert property ($fell(st_r.busy) |->
        st_r.latch == {4{LATCH_ERASED}})
        else $error("latches not erased after long write");
    a_done_flag: assert property ($fell(st_r.busy) |-> st_r.done_flag && !st_r.wr)
        else $error("done flag missing after long write");
    a_stall_hold: assert property ($rose(cpu_stall_o) |-> cpu_stall_o[*8])
        else $error("stall dropped too early");
    a_stall_end: assert property (cpu_stall_o
        && st_r.cnt == CNT_W'(LONG_WRITE_CYCLES - 1) |=> !cpu_stall_o)
        else $error("stall outlasted the long write time");
    // External access gates.
    a_ext_gate: assert property (cp_prog_i |=> !ext_grant_o.pm_read
        && !ext_grant_o.pm_write)
        else $error("external program access while protected");
    a_ee_gate: assert property (cp_data_i |=> !ext_grant_o.ee_access
        && !ext_grant_o.pm_write)
        else $error("external access while data protected");
    // Unlock port behaviour.
    a_unlock_read: assert property (bus_i.rd_en && bus_i.addr == OFF_UNLOCK
        |=> rdata_o == 8'h00)
        else $error("unlock port returned data");
    a_unlock_reset: assert property (bus_i.wr_en && !wr_unlock && !wr_control
        |=> st_r.unlock == UNL_IDLE)
        else $error("unlock detector survived other write");

endmodule // flash_block_write_sequencer

/* dv/test_flash_block_write_sequencer.sv */
// Self-checking testbench for the flash block write sequencer.
// Assumes the design package is compiled first and drives every port itself.
`timescale 1ns/1ps

module test_flash_block_write_sequencer;
    import nvm_seq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Short counts keep the run brief; the waits and the stall length check derive from these.
    localparam int PWRT = 50;
    localparam int LW = 20;

    logic core_clk_i = 1'b0; // Core clock, 100 ns period.
    logic resetn_i = 1'b0; // Synchronous reset, active low.
    bus_req_s bus_i = '0; // Register bus request.
    logic [1:0] wp_sel = 2'h3; // No protected segment at start.
    logic cp_data = 1'b0; // Data code protection off.
    logic cp_prog = 1'b0; // Program code protection off.
    logic [7:0] rdata_o; // Read data from the design.
    prog_cmd_s prog_o; // Block program command.
    prog_cmd_s cap; // Last command seen with start high.
    ext_grant_s grant; // External port grants.
    logic cpu_stall_o; // Core stall level.
    logic nvm_irq_o; // Completion interrupt level.
    int num_errors = 0; // Mismatches seen.
    int comparisons = 0; // Comparisons made.
    int starts = 0; // Start pulses seen.
    int stall_len = 0; // Cycles with the core stalled.

    // The clock toggles every half period.
    always #50 core_clk_i = ~core_clk_i;

    flash_block_write_sequencer #(.PWRT_CYCLES(PWRT), .LONG_WRITE_CYCLES(LW)) dut_u (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .bus_i(bus_i),
        .rdata_o(rdata_o),
        .write_protect_select_i(wp_sel),
        .cp_data_i(cp_data),
        .cp_prog_i(cp_prog),
        .prog_o(prog_o),
        .cpu_stall_o(cpu_stall_o),
        .nvm_irq_o(nvm_irq_o),
        .ext_grant_o(grant)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Start pulses and stall cycles are counted so that a repeated or long
    // pulse shows up as a wrong count.
    always @(posedge core_clk_i) begin
        if (prog_o.start === 1'b1) begin
            starts++;
            cap = prog_o;
        end
        if (cpu_stall_o === 1'b1) begin
            stall_len++;
        end
    end

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Raises a write for one edge; the strobe is left up for the next caller.
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        bus_i = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
        @(posedge core_clk_i);
        #1;
    endtask

    // Drops the bus and lets some edges pass.
    task automatic idle(input int n);
        bus_i = '0;
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    // Reads one register and compares the data of the following cycle.
    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        bus_i = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk_i);
        #1;
        check(rdata_o, exp);
        idle(1);
    endtask

    // One word load: select, address, data, keys, trigger; brk slips a write
    // between the two keys.
    // Select, keys, trigger.
    task automatic word(input logic [10:0] a, input logic [13:0] d,
                        input logic [7:0] ctl, input bit brk);
        wr(OFF_CONTROL, 8'h84);
        wr(OFF_ADDR_HIGH, {5'h00, a[10:8]});
        wr(OFF_ADDR_LOW, a[7:0]);
        wr(OFF_DATA_LOW, d[7:0]);
        wr(OFF_DATA_HIGH, {2'h0, d[13:8]});
        wr(OFF_UNLOCK, KEY_FIRST);
        if (brk) begin
            wr(OFF_DATA_LOW, d[7:0]);
        end
        wr(OFF_UNLOCK, KEY_SECOND);
        wr(OFF_CONTROL, ctl);
        idle(3);
    endtask

    // Prints the verdict and ends the run.
    task automatic close_out();
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence of tests.
    initial begin
        repeat (20) @(posedge core_clk_i);
        #1;
        resetn_i = 1'b1;
        rd(OFF_INT_FLAGS_2, 8'h00);
        rd(OFF_INT_ENABLES_2, 8'h00);
        rd(OFF_CONTROL, 8'h00);
        wr(OFF_UNLOCK, KEY_FIRST);
        rd(OFF_UNLOCK, 8'h00);
        rd(9'h1FF, 8'h00);
        // A long-write trigger while the power-up hold runs is refused.
        word(11'h203, 14'h0001, 8'h86, 1'b0);
        check(starts, 0);
        idle(PWRT + 10);
        // Segment 0x000-0x1FF protected; its top block is refused.
        wp_sel = 2'h2;
        word(11'h1FF, 14'h0002, 8'h86, 1'b0);
        check(starts, 0);
        // Erase requests, data-space triggers, triggers without write enable and a broken key sequence are refused.
        word(11'h203, 14'h0005, 8'h96, 1'b0);
        check(starts, 0);
        word(11'h203, 14'h0006, 8'h06, 1'b0);
        check(starts, 0);
        word(11'h203, 14'h0003, 8'h82, 1'b0);
        check(starts, 0);
        word(11'h203, 14'h0004, 8'h86, 1'b1);
        check(starts, 0);
        rd(OFF_CONTROL, 8'h84);
        wr(OFF_INT_ENABLES_2, 8'h10);
        idle(1);
        // Full block just above the protected segment.
        // Target block taken as erased.
        for (int i = 0; i < 4; i++) begin
            word(11'h200 + 11'(i), 14'h2A50 + 14'(i), 8'h86, 1'b0);
            if (i < 3) begin
                rd(OFF_CONTROL, 8'h84);
                check(cpu_stall_o, 1'b0);
            end
        end
        idle(LW + 5);
        check(starts, 1);
        check(cap.addr, 11'h200);
        for (int i = 0; i < 4; i++) begin
            check(cap.words[i], 14'h2A50 + 14'(i));
        end
        check(stall_len, LW);
        check(nvm_irq_o, 1'b1);
        rd(OFF_INT_FLAGS_2, 8'h10);
        rd(OFF_CONTROL, 8'h84);
        wr(OFF_INT_FLAGS_2, 8'h00);
        idle(2);
        check(nvm_irq_o, 1'b0);
        // Only the last word is loaded, so the others must read erased.
        word(11'h207, 14'h0155, 8'h86, 1'b0);
        idle(LW + 5);
        check(starts, 2);
        check(cap.addr, 11'h204);
        for (int i = 0; i < 3; i++) begin
            check(cap.words[i], LATCH_ERASED);
        end
        check(cap.words[3], 14'h0155);
        // The two wider protected segments refuse their top blocks.
        wp_sel = 2'h1;
        word(11'h3FF, 14'h0007, 8'h86, 1'b0);
        check(starts, 2);
        wp_sel = 2'h0;
        word(11'h7FF, 14'h0008, 8'h86, 1'b0);
        check(starts, 2);
        // Every code protection combination against the external grants.
        for (int i = 0; i < 4; i++) begin
            cp_data = i[0];
            cp_prog = i[1];
            idle(2);
            check({grant.pm_read, grant.pm_write, grant.ee_access},
                  {~cp_prog, ~(cp_prog | cp_data), ~cp_data});
        end
        close_out();
    end

    // Watchdog that ends a hung run as a failure.
    initial begin
        repeat (3000) @(posedge core_clk_i);
        num_errors++;
        close_out();
    end

endmodule // test_flash_block_write_sequencer
